/* pkg/debi_defines.vh */
// Constants for the dual external bus interface
`ifndef DEBI_DEFINES_VH
`define DEBI_DEFINES_VH
`define DEBI_PDATA_W 32
`define DEBI_PADDR_W 24
`define DEBI_XDATA_W 32
`define DEBI_XADDR_W 13
`define DEBI_RW_READ 1'b1
`define DEBI_RW_WRITE 1'b0
`define DEBI_STROBE_ON 1'b0
`define DEBI_STROBE_OFF 1'b1
`define DEBI_OE_DRIVE 1'b0
`define DEBI_OE_FLOAT 1'b1
`define DEBI_RESET_VECTOR 24'h000000
`define DEBI_SYNC_LAG 2'h2
`endif

/* hdl/debi_xbus.v */
// Expansion bus master engine with memory and I/O strobes
`timescale 1ns/1ns
`default_nettype none
`include "debi_defines.vh"
module debi_xbus (
  input  wire        mclk_in,
  input  wire        rst_in,
  input  wire        ce_in,
  input  wire        req_in,
  input  wire        write_in,
  input  wire        io_space_in,
  input  wire [12:0] addr_in,
  input  wire [31:0] wdata_in,
  input  wire        ready_sync_in,
  input  wire [31:0] data_sync_in,
  output reg         busy_out,
  output reg         done_out,
  output reg  [31:0] rdata_out,
  output reg  [12:0] expansion_address_bus_out,
  output reg  [31:0] expansion_data_bus_out,
  output reg         expansion_data_bus_oe_n_out,
  output reg         expansion_read_write_out,
  output reg         expansion_memory_strobe_n_out,
  output reg         expansion_io_space_strobe_n_out
);
  reg [1:0] age;

  // Idle/active flag; the strobe stays on until ready falls low
  always @(posedge mclk_in) begin
    if (rst_in) begin
      age                             <= 2'h0;
      busy_out                        <= 1'b0;
      done_out                        <= 1'b0;
      rdata_out                       <= 32'h00000000;
      expansion_address_bus_out       <= 13'h0000;
      expansion_data_bus_out          <= 32'h00000000;
      expansion_data_bus_oe_n_out     <= `DEBI_OE_FLOAT;
      expansion_read_write_out        <= `DEBI_RW_READ;
      expansion_memory_strobe_n_out   <= `DEBI_STROBE_OFF;
      expansion_io_space_strobe_n_out <= `DEBI_STROBE_OFF;
    end else if (ce_in) begin
      done_out <= 1'b0;
      if (!busy_out && req_in) begin
        busy_out                  <= 1'b1;
        age                       <= 2'h0;
        expansion_address_bus_out <= addr_in;
        expansion_data_bus_out    <= wdata_in;
        expansion_data_bus_oe_n_out <= write_in ? `DEBI_OE_DRIVE : `DEBI_OE_FLOAT;
        expansion_read_write_out  <= write_in ? `DEBI_RW_WRITE : `DEBI_RW_READ;
        // Only the strobe of the addressed space is asserted
        expansion_memory_strobe_n_out   <= io_space_in ? `DEBI_STROBE_OFF
                                                       : `DEBI_STROBE_ON;
        expansion_io_space_strobe_n_out <= io_space_in ? `DEBI_STROBE_ON
                                                       : `DEBI_STROBE_OFF;
      end else if (busy_out && (age != `DEBI_SYNC_LAG)) begin
        // Synchronised ready still shows the pin from before the strobe
        age <= age + 2'h1;
      end else if (busy_out && !ready_sync_in) begin
        // Address and data held while ready stays high
        busy_out                        <= 1'b0;
        done_out                        <= 1'b1;
        rdata_out                       <= data_sync_in;
        expansion_data_bus_oe_n_out     <= `DEBI_OE_FLOAT;
        expansion_read_write_out        <= `DEBI_RW_READ;
        expansion_memory_strobe_n_out   <= `DEBI_STROBE_OFF;
        expansion_io_space_strobe_n_out <= `DEBI_STROBE_OFF;
      end
    end
  end
endmodule // debi_xbus
`default_nettype wire

/* hdl/debi_top.v */
// Dual external bus interface: primary bus with hold, plus expansion bus
`timescale 1ns/1ns
`default_nettype none
`include "debi_defines.vh"
module debi_top (
  input  wire        mclk_in,
  input  wire        rst_in,
  input  wire        ce_in,
  input  wire        p_req_in,
  input  wire        p_write_in,
  input  wire [23:0] p_addr_in,
  input  wire [31:0] p_wdata_in,
  output reg         p_busy_out,
  output reg         p_done_out,
  output reg  [31:0] p_rdata_out,
  output reg  [23:0] boot_vector_out,
  input  wire        x_req_in,
  input  wire        x_write_in,
  input  wire        x_io_space_in,
  input  wire [12:0] x_addr_in,
  input  wire [31:0] x_wdata_in,
  output wire        x_busy_out,
  output wire        x_done_out,
  output wire [31:0] x_rdata_out,
  input  wire [31:0] primary_data_bus_in,
  output reg  [31:0] primary_data_bus_out,
  output reg         primary_data_bus_oe_n_out,
  output reg  [23:0] primary_address_bus_out,
  output reg         primary_address_bus_oe_n_out,
  output reg         primary_read_write_out,
  output reg         primary_read_write_oe_n_out,
  output reg         primary_access_strobe_n_out,
  output reg         primary_access_strobe_oe_n_out,
  input  wire        primary_ready_in,
  input  wire        bus_grab_req_n_in,
  output reg         bus_grab_ack_n_out,
  input  wire [31:0] expansion_data_bus_in,
  output wire [31:0] expansion_data_bus_out,
  output wire        expansion_data_bus_oe_n_out,
  output wire [12:0] expansion_address_bus_out,
  output wire        expansion_address_bus_oe_n_out,
  output wire        expansion_read_write_out,
  output wire        expansion_read_write_oe_n_out,
  output wire        expansion_memory_strobe_n_out,
  output wire        expansion_memory_strobe_oe_n_out,
  output wire        expansion_io_space_strobe_n_out,
  output wire        expansion_io_space_strobe_oe_n_out,
  input  wire        expansion_ready_in
);
  // One-hot primary bus states
  localparam [3:0] ST_IDLE = 4'h1;
  localparam [3:0] ST_XFER = 4'h2;
  localparam [3:0] ST_HOLD = 4'h4;
  localparam [3:0] ST_REL  = 4'h8;

  reg [3:0]  state;
  reg        prdy_s1;
  reg        prdy_s2;
  reg        hold_s1;
  reg        hold_s2;
  reg        expansion_ready_in_s1;
  reg        expansion_ready_in_s2;
  reg [31:0] pdat_s1;
  reg [31:0] pdat_s2;
  reg [31:0] xdat_s1;
  reg [31:0] xdat_s2;
  reg        p_wr;
  reg [1:0]  p_age;

  // Pin inputs pass two flops; only the second stage is read
  always @(posedge mclk_in) begin
    if (rst_in) begin
      prdy_s1 <= 1'b1;
      prdy_s2 <= 1'b1;
      hold_s1 <= 1'b1;
      hold_s2 <= 1'b1;
      expansion_ready_in_s1 <= 1'b1;
      expansion_ready_in_s2 <= 1'b1;
      pdat_s1 <= 32'h00000000;
      pdat_s2 <= 32'h00000000;
      xdat_s1 <= 32'h00000000;
      xdat_s2 <= 32'h00000000;
    end else if (ce_in) begin
      prdy_s1 <= primary_ready_in;
      prdy_s2 <= prdy_s1;
      hold_s1 <= bus_grab_req_n_in;
      hold_s2 <= hold_s1;
      expansion_ready_in_s1 <= expansion_ready_in;
      expansion_ready_in_s2 <= expansion_ready_in_s1;
      pdat_s1 <= primary_data_bus_in;
      pdat_s2 <= pdat_s1;
      xdat_s1 <= expansion_data_bus_in;
      xdat_s2 <= xdat_s1;
    end
  end

  // Primary bus sequencer; hold is only honoured between accesses
  always @(posedge mclk_in) begin
    if (rst_in) begin
      state                          <= ST_IDLE;
      boot_vector_out                <= `DEBI_RESET_VECTOR;
      p_busy_out                     <= 1'b0;
      p_done_out                     <= 1'b0;
      p_rdata_out                    <= 32'h00000000;
      p_wr                           <= 1'b0;
      p_age                          <= 2'h0;
      primary_data_bus_out           <= 32'h00000000;
      primary_data_bus_oe_n_out      <= `DEBI_OE_FLOAT;
      primary_address_bus_out        <= 24'h000000;
      primary_address_bus_oe_n_out   <= `DEBI_OE_DRIVE;
      primary_read_write_out         <= `DEBI_RW_READ;
      primary_read_write_oe_n_out    <= `DEBI_OE_DRIVE;
      primary_access_strobe_n_out    <= `DEBI_STROBE_OFF;
      primary_access_strobe_oe_n_out <= `DEBI_OE_DRIVE;
      bus_grab_ack_n_out             <= 1'b1;
    end else if (ce_in) begin
      p_done_out <= 1'b0;
      case (state)
        ST_IDLE: begin
          if (!hold_s2) begin
            // Float everything the outside master may take over
            state                          <= ST_HOLD;
            primary_data_bus_oe_n_out      <= `DEBI_OE_FLOAT;
            primary_address_bus_oe_n_out   <= `DEBI_OE_FLOAT;
            primary_read_write_oe_n_out    <= `DEBI_OE_FLOAT;
            primary_access_strobe_oe_n_out <= `DEBI_OE_FLOAT;
            bus_grab_ack_n_out             <= 1'b0;
          end else if (p_req_in) begin
            state                       <= ST_XFER;
            p_busy_out                  <= 1'b1;
            p_wr                        <= p_write_in;
            p_age                       <= 2'h0;
            primary_address_bus_out     <= p_addr_in;
            primary_data_bus_out        <= p_wdata_in;
            primary_data_bus_oe_n_out   <= p_write_in ? `DEBI_OE_DRIVE : `DEBI_OE_FLOAT;
            primary_read_write_out      <= p_write_in ? `DEBI_RW_WRITE : `DEBI_RW_READ;
            primary_access_strobe_n_out <= `DEBI_STROBE_ON;
          end
        end
        ST_XFER: begin
          // Ready high stretches the access with bus lines frozen
          if (p_age != `DEBI_SYNC_LAG) begin
            // Synchronised ready still shows the pin from before the strobe
            p_age <= p_age + 2'h1;
          end else if (!prdy_s2) begin
            state                       <= ST_IDLE;
            p_busy_out                  <= 1'b0;
            p_done_out                  <= 1'b1;
            if (!p_wr) begin
              p_rdata_out <= pdat_s2;
            end
            primary_data_bus_oe_n_out   <= `DEBI_OE_FLOAT;
            primary_read_write_out      <= `DEBI_RW_READ;
            primary_access_strobe_n_out <= `DEBI_STROBE_OFF;
          end
        end
        ST_HOLD: begin
          // Stay floated until the request is withdrawn
          if (hold_s2) begin
            state              <= ST_REL;
            bus_grab_ack_n_out <= 1'b1;
          end
        end
        ST_REL: begin
          // One cycle gap after ack rises so the other master can let go
          state                          <= ST_IDLE;
          primary_address_bus_oe_n_out   <= `DEBI_OE_DRIVE;
          primary_read_write_oe_n_out    <= `DEBI_OE_DRIVE;
          primary_access_strobe_oe_n_out <= `DEBI_OE_DRIVE;
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  // Expansion bus has no hold, so its address, direction and strobe enables stay driven
  assign expansion_address_bus_oe_n_out     = `DEBI_OE_DRIVE;
  assign expansion_read_write_oe_n_out      = `DEBI_OE_DRIVE;
  assign expansion_memory_strobe_oe_n_out   = `DEBI_OE_DRIVE;
  assign expansion_io_space_strobe_oe_n_out = `DEBI_OE_DRIVE;

  debi_xbus u_xbus (
    .mclk_in                         (mclk_in),
    .rst_in                          (rst_in),
    .ce_in                           (ce_in),
    .req_in                          (x_req_in),
    .write_in                        (x_write_in),
    .io_space_in                     (x_io_space_in),
    .addr_in                         (x_addr_in),
    .wdata_in                        (x_wdata_in),
    .ready_sync_in                   (expansion_ready_in_s2),
    .data_sync_in                    (xdat_s2),
    .busy_out                        (x_busy_out),
    .done_out                        (x_done_out),
    .rdata_out                       (x_rdata_out),
    .expansion_address_bus_out       (expansion_address_bus_out),
    .expansion_data_bus_out          (expansion_data_bus_out),
    .expansion_data_bus_oe_n_out     (expansion_data_bus_oe_n_out),
    .expansion_read_write_out        (expansion_read_write_out),
    .expansion_memory_strobe_n_out   (expansion_memory_strobe_n_out),
    .expansion_io_space_strobe_n_out (expansion_io_space_strobe_n_out)
  );
endmodule // debi_top
`default_nettype wire

/* testbench/debi_props.sv */
// Port checker for the dual external bus interface
`timescale 1ns/1ns
`default_nettype none
`include "debi_defines.vh"
module debi_props (
  input wire logic        mclk_in,
  input wire logic        rst_in,
  input wire logic        p_busy_out,
  input wire logic [23:0] boot_vector_out,
  input wire logic [23:0] primary_address_bus_out,
  input wire logic        primary_address_bus_oe_n_out,
  input wire logic        primary_data_bus_oe_n_out,
  input wire logic        primary_read_write_out,
  input wire logic        primary_read_write_oe_n_out,
  input wire logic        primary_access_strobe_n_out,
  input wire logic        primary_access_strobe_oe_n_out,
  input wire logic        primary_ready_in,
  input wire logic        bus_grab_req_n_in,
  input wire logic        bus_grab_ack_n_out,
  input wire logic        x_busy_out,
  input wire logic [12:0] expansion_address_bus_out,
  input wire logic        expansion_data_bus_oe_n_out,
  input wire logic        expansion_read_write_out,
  input wire logic        expansion_memory_strobe_n_out,
  input wire logic        expansion_io_space_strobe_n_out,
  input wire logic        expansion_ready_in
);
  default clocking @(posedge mclk_in); endclocking
  default disable iff (rst_in);
  // Primary strobe qualified by its drive enable, so a floated line never counts; expansion strobes are used unqualified
  wire p_primary_access_strobe = !primary_access_strobe_n_out && !primary_access_strobe_oe_n_out;
  wire x_primary_access_strobe = !expansion_memory_strobe_n_out || !expansion_io_space_strobe_n_out;
  // Hold release: acknowledge first, then the address lines return
  sequence ack_back; ##[1:6] bus_grab_ack_n_out; endsequence
  sequence drive_back; ##[1:4] !primary_address_bus_oe_n_out; endsequence
  p_strobe_a: assert property (p_busy_out |-> p_primary_access_strobe)
    else $error("primary access without strobe");
  p_rw_a: assert property (p_primary_access_strobe |-> primary_read_write_out == primary_data_bus_oe_n_out)
    else $error("primary direction wrong");
  p_ready_a: assert property (p_primary_access_strobe && primary_ready_in |=> p_primary_access_strobe && $stable(primary_address_bus_out))
    else $error("primary access ended while ready high");
  x_strobe_a: assert property (!(!expansion_memory_strobe_n_out && !expansion_io_space_strobe_n_out))
    else $error("both expansion strobes active");
  x_busy_a: assert property (x_busy_out == x_primary_access_strobe)
    else $error("expansion busy without its strobe");
  x_rw_a: assert property (x_primary_access_strobe |-> expansion_read_write_out == expansion_data_bus_oe_n_out)
    else $error("expansion direction wrong");
  x_ready_a: assert property (x_primary_access_strobe && expansion_ready_in |=> x_primary_access_strobe && $stable(expansion_address_bus_out))
    else $error("expansion access ended while ready high");
  hold_float_a: assert property (!bus_grab_ack_n_out |-> primary_address_bus_oe_n_out && primary_data_bus_oe_n_out && primary_read_write_oe_n_out && primary_access_strobe_oe_n_out && !p_busy_out)
    else $error("primary bus driven during hold");
  hold_ack_a: assert property ($fell(bus_grab_req_n_in) |-> ##[1:40] !bus_grab_ack_n_out)
    else $error("hold not acknowledged");
  hold_release_a: assert property ($rose(bus_grab_req_n_in) |-> ack_back ##0 drive_back)
    else $error("hold release not followed");
  reset_state_a: assert property ($fell(rst_in) |-> primary_access_strobe_n_out && bus_grab_ack_n_out && !p_busy_out && boot_vector_out == `DEBI_RESET_VECTOR)
    else $error("reset state wrong");
endmodule // debi_props
bind debi_top debi_props u_props (.*);
`default_nettype wire

/* testbench/debi_mem_model.sv */
// Behavioural memory answering on one bus of the interface
`timescale 1ns/1ns
`default_nettype none
module debi_mem_model (
  input  wire logic        mclk_in,
  input  wire logic        rst_in,
  input  wire logic        strobe_n_in,
  input  wire logic        rw_in,
  input  wire logic [23:0] addr_in,
  input  wire logic [31:0] wdata_in,
  input  wire logic [3:0]  wait_in,
  output var  logic        ready_out,
  output var  logic [31:0] rdata_out,
  output var  logic [31:0] wword_out
);
  logic [3:0] cnt;
  // Ready high stretches the access; low holds until the strobe ends
  always @(posedge mclk_in) begin
    if (rst_in || strobe_n_in) begin
      cnt <= 4'h0;
      ready_out <= 1'b1;
    end else if (cnt < wait_in) begin
      cnt <= cnt + 4'h1;
    end else begin
      ready_out <= 1'b0;
    end
  end
  // Outside a read the lines toggle, so stale data can never pass as a match
  always @(posedge mclk_in) begin
    if (rst_in) begin
      rdata_out <= 32'h0;
    end else if (!strobe_n_in && rw_in) begin
      rdata_out <= {8'hC3, addr_in};
    end else begin
      rdata_out <= ~rdata_out;
    end
    if (!strobe_n_in && !rw_in) begin
      wword_out <= wdata_in;
    end
  end
endmodule // debi_mem_model
`default_nettype wire

/* testbench/test_dual_external_bus_interface.sv */
// Self-checking bench for the dual external bus interface
`timescale 1ns/1ns
`default_nettype none
`include "debi_defines.vh"
module test_dual_external_bus_interface;
  logic mclk_in = 1'b0;
  logic rst_in = 1'b1;
  logic p_req = 1'b0, x_req = 1'b0, wr = 1'b0, io = 1'b0, hold_n = 1'b1;
  logic [23:0] ad = 24'h0;
  logic [31:0] wd = 32'h0, got;
  logic [3:0] pw = 4'h2, xw = 4'h2;
  logic [1:0] seen;
  int miscompares = 0, check_count = 0, n;
  wire p_busy, p_done, x_busy, x_done, pd_oe_n, pa_oe_n, prw, prw_oe_n, ps_n, ps_oe_n;
  wire p_rdy, ack_n, xd_oe_n, xrw, xm_n, xi_n, x_rdy;
  wire [23:0] boot_vec, pa;
  wire [12:0] xa;
  wire [31:0] p_rdata, x_rdata, pd_out, xd_out, pmem_rd, xmem_rd, pword, xword;
  // Bus levels: a floated strobe is pulled up, a floated data bus shows the memory
  wire ps_wire = ps_oe_n ? 1'b1 : ps_n;
  wire [31:0] pd_in = pd_oe_n ? pmem_rd : pd_out;
  wire [31:0] xd_in = xd_oe_n ? xmem_rd : xd_out;
  // Columns: bus, write, io, address, data, expected word, expected strobes
  logic [92:0] rows [6] = '{{3'h0, 24'hABCDEF, 32'h0, 32'hC3ABCDEF, 2'h0},
    {3'h2, 24'h000010, 32'hA5A55A5A, 32'hA5A55A5A, 2'h0},
    {3'h4, 24'h001FFF, 32'h0, 32'hC3001FFF, 2'h1},
    {3'h6, 24'h000001, 32'h12345678, 32'h12345678, 2'h1},
    {3'h5, 24'h000AAA, 32'h0, 32'hC3000AAA, 2'h2},
    {3'h7, 24'h001234, 32'hFEDCBA98, 32'hFEDCBA98, 2'h2}};
  always #20 mclk_in = ~mclk_in;
  debi_top dut (.mclk_in(mclk_in), .rst_in(rst_in), .ce_in(1'b1), .p_req_in(p_req),
    .p_write_in(wr), .p_addr_in(ad), .p_wdata_in(wd), .p_busy_out(p_busy),
    .p_done_out(p_done), .p_rdata_out(p_rdata), .boot_vector_out(boot_vec),
    .x_req_in(x_req), .x_write_in(wr), .x_io_space_in(io), .x_addr_in(ad[12:0]),
    .x_wdata_in(wd), .x_busy_out(x_busy), .x_done_out(x_done), .x_rdata_out(x_rdata),
    .primary_data_bus_in(pd_in), .primary_data_bus_out(pd_out),
    .primary_data_bus_oe_n_out(pd_oe_n), .primary_address_bus_out(pa),
    .primary_address_bus_oe_n_out(pa_oe_n), .primary_read_write_out(prw),
    .primary_read_write_oe_n_out(prw_oe_n), .primary_access_strobe_n_out(ps_n),
    .primary_access_strobe_oe_n_out(ps_oe_n), .primary_ready_in(p_rdy),
    .bus_grab_req_n_in(hold_n), .bus_grab_ack_n_out(ack_n), .expansion_data_bus_in(xd_in),
    .expansion_data_bus_out(xd_out), .expansion_data_bus_oe_n_out(xd_oe_n),
    .expansion_address_bus_out(xa), .expansion_address_bus_oe_n_out(),
    .expansion_read_write_out(xrw), .expansion_read_write_oe_n_out(),
    .expansion_memory_strobe_n_out(xm_n), .expansion_memory_strobe_oe_n_out(),
    .expansion_io_space_strobe_n_out(xi_n), .expansion_io_space_strobe_oe_n_out(),
    .expansion_ready_in(x_rdy));
  debi_mem_model u_pmem (.mclk_in(mclk_in), .rst_in(rst_in), .strobe_n_in(ps_wire),
    .rw_in(prw), .addr_in(pa), .wdata_in(pd_in), .wait_in(pw), .ready_out(p_rdy),
    .rdata_out(pmem_rd), .wword_out(pword));
  debi_mem_model u_xmem (.mclk_in(mclk_in), .rst_in(rst_in), .strobe_n_in(xm_n & xi_n),
    .rw_in(xrw), .addr_in({11'h0, xa}), .wdata_in(xd_in), .wait_in(xw), .ready_out(x_rdy),
    .rdata_out(xmem_rd), .wword_out(xword));
  task automatic check(input logic [31:0] seen_v, input logic [31:0] exp_v);
    check_count++;
    if (seen_v !== exp_v) begin
      miscompares++;
      $display("Error at %0t: got %h expected %h", $time, seen_v, exp_v);
    end
  endtask
  task automatic complete_run;
    $display("Comparisons %0d, mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // One request, dropped after it is taken; n counts cycles until done
  task automatic acc(input logic x, w, i, input logic [23:0] a, input logic [31:0] d);
    seen = 2'h0;
    @(posedge mclk_in);
    p_req <= !x;
    x_req <= x;
    wr <= w;
    io <= i;
    ad <= a;
    wd <= d;
    @(posedge mclk_in);
    p_req <= 1'b0;
    x_req <= 1'b0;
    for (n = 1; n < 60; n++) begin
      @(posedge mclk_in);
      #1;
      seen = seen | {!xi_n, !xm_n};
      if ((x ? x_done : p_done) === 1'b1) break;
    end
    if (n == 60) begin
      miscompares++;
      complete_run();
    end
    got = x ? (w ? xword : x_rdata) : (w ? pword : p_rdata);
  endtask
  task automatic wait_ack(input logic v);
    for (n = 0; n < 40 && ack_n !== v; n++) begin
      @(posedge mclk_in);
      #1;
    end
    if (n == 40) begin
      miscompares++;
      complete_run();
    end
  endtask
  initial begin
    repeat (12) @(posedge mclk_in);
    rst_in <= 1'b0;
    #1;
    check({ps_n, ack_n, prw, pd_oe_n, p_busy, xm_n, xi_n}, 7'h7B);
    check(boot_vec, `DEBI_RESET_VECTOR);
    for (int k = 0; k < 6; k++) begin
      acc(rows[k][92], rows[k][91], rows[k][90], rows[k][89:66], rows[k][65:34]);
      check(got, rows[k][33:2]);
      check(seen, rows[k][1:0]);
    end
    // Slow partners must stretch both buses
    pw = 4'h6;
    xw = 4'h6;
    acc(1'b0, 1'b1, 1'b0, 24'h800001, 32'h0F0F0F0F);
    check(got, 32'h0F0F0F0F);
    check(32'(n >= 8), 32'h1);
    acc(1'b1, 1'b0, 1'b1, 24'h000F0F, 32'h0);
    check(32'(n >= 8), 32'h1);
    check(got, 32'hC3000F0F);
    // Hold arrives in mid access: the access still finishes
    pw = 4'h4;
    fork
      acc(1'b0, 1'b0, 1'b0, 24'h5A5A5A, 32'h0);
      begin
        repeat (3) @(posedge mclk_in);
        hold_n <= 1'b0;
      end
    join
    check(got, 32'hC35A5A5A);
    wait_ack(1'b0);
    check({pd_oe_n, pa_oe_n, prw_oe_n, ps_oe_n, ack_n}, 5'h1E);
    @(posedge mclk_in);
    p_req <= 1'b1;
    repeat (4) @(posedge mclk_in);
    #1;
    check({p_busy, ps_oe_n}, 2'h1);
    @(posedge mclk_in);
    p_req <= 1'b0;
    hold_n <= 1'b1;
    wait_ack(1'b1);
    acc(1'b0, 1'b0, 1'b0, 24'h000123, 32'h0);
    check(got, 32'hC3000123);
    // Reset in mid access must drop the primary strobe, direction, data enable, busy and done to their idle levels
    @(posedge mclk_in);
    p_req <= 1'b1;
    wr <= 1'b1;
    @(posedge mclk_in);
    p_req <= 1'b0;
    repeat (2) @(posedge mclk_in);
    rst_in <= 1'b1;
    repeat (3) @(posedge mclk_in);
    rst_in <= 1'b0;
    #1;
    check({ps_n, prw, pd_oe_n, p_busy, p_done}, 5'h1C);
    acc(1'b0, 1'b0, 1'b0, 24'h000456, 32'h0);
    check(got, 32'hC3000456);
    complete_run();
  end
endmodule // test_dual_external_bus_interface
`default_nettype wire
